//--- rtl/lsks_dev.sv
// Device end: frame sequencer, key scan, display memory and link slave
// Notes on behaviour
// - Memory one drives output high, zero low
// - First slot scans 16 keys for 64 us
// - Second slot drives discrete LEDs, 512 us
// - Further slots drive configured seven-segment digits
// - Default configuration gives four slots per frame
// - LED slot only after LED memory written
// - Frames repeat forever, nothing can stop them
// - Key matrix stored into key memory per frame
// - Host: strobe low 1 us around clocking
// - Host: strobe low at least 9 us
// - Host: clock at most 1 MHz, 50 percent
// - Device drives read data after command byte
// - Host releases data line after command byte
// - Read data valid from next falling edge
// - Host drives commands, device drives read data
// - Page one reads LED and key bytes
// - Reading a key byte clears its half of the key interrupt; both halves must clear to release it
// - Digit count from configuration byte low bits
// - Pointer advances unless fixed-address mode
module lsks_dev
	import lsks_pkg::*;
#(
	parameter int unsigned LED_SLOT_CYC_P = LED_SLOT_CYC,
	parameter int unsigned DIG_SLOT_CYC_P = LED_SLOT_CYC
) (
	input wire logic clk,
	input wire logic rstn,
	lsks_link_if.dev_mp link,
	input wire logic [1:0] key_in,
	output logic [7:0] seg_out,
	output logic [DIG_W-1:0] dig_out,
	output logic key_event_irq_n
);
	function automatic logic [2:0] digit_count(input logic [7:0] cfg);
		digit_count = (cfg[2:0] == 3'h0) ? 3'h1 : ((cfg[2:0] > DIG_MAX) ? DIG_MAX : cfg[2:0]);
	endfunction : digit_count

	function automatic logic [2:0] next_ptr(input logic [2:0] p, input logic rd);
		next_ptr = (rd && p == ADDR_KEY_HI) ? ADDR_LED : p + 3'h1;
	endfunction : next_ptr

	function automatic logic [7:0] rd_byte(input lsks_page_e pg, input logic [2:0] p,
		input logic [7:0] led, input logic [15:0] key);
		rd_byte = MEM_RESET;
		if (pg == PG_LED) begin
			unique case (p)
				ADDR_LED: rd_byte = led;
				ADDR_KEY_LO: rd_byte = key[7:0];
				ADDR_KEY_HI: rd_byte = key[15:8];
				default: rd_byte = MEM_RESET;
			endcase
		end
	endfunction : rd_byte

	// Link clock domain
	logic link_rst_n;
	logic [7:0] sh_q;
	logic [2:0] bit_q;
	logic cmd_ok_q;
	logic rd_q;
	logic fix_q;
	lsks_page_e page_q;
	logic [2:0] ptr_q;
	logic [7:0] byte_d;
	logic wr_tgl_q;
	logic rd_tgl_q;
	lsks_page_e ev_page_q;
	logic [2:0] ev_ptr_q;
	logic [7:0] ev_data_q;
	logic sdo_q;
	logic oe_q;
	logic [7:0] rd_sel;
	// Device clock domain
	logic [SY_W-1:0] sy1_q;
	logic [SY_W-1:0] sy2_q;
	logic [SY_W-1:0] sy3_q;
	logic [SY_W-1:0] sv_q;
	logic [SY_W-1:0] svp_q;
	logic wr_ev;
	logic rd_ev;
	logic [7:0] seg_mem_q [6];
	logic [7:0] led_mem_q;
	logic led_seen_q;
	logic [7:0] cfg_q;
	lsks_slot_e slot_q;
	logic [CNT_W-1:0] tick_q;
	logic [CNT_W-1:0] step_q;
	logic [2:0] col_q;
	logic [2:0] didx_q;
	logic [15:0] acc_q;
	logic [15:0] key_q;
	logic [15:0] snap_key_q;
	logic [7:0] snap_led_q;
	logic [1:0] pend_q;
	logic [1:0] pend_d;
	logic irq_n_q;
	logic [7:0] seg_q;
	logic [DIG_W-1:0] dig_q;
	logic slot_last;
	logic frame_end;
	logic [CNT_W-1:0] slot_len;

	assign link_rst_n = rstn & ~link.strobe_select;
	assign byte_d = {link.sdio, sh_q[7:1]};
	assign rd_sel = rd_byte(page_q, ptr_q, snap_led_q, snap_key_q);

	always_ff @(posedge link.sclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			sh_q <= MEM_RESET;
			bit_q <= '0;
			cmd_ok_q <= 1'b0;
			rd_q <= 1'b0;
			fix_q <= 1'b0;
			page_q <= PG_SEG;
			ptr_q <= '0;
		end else begin
			sh_q <= byte_d;
			bit_q <= bit_q + 3'h1;
			if (bit_q == BIT_LAST) begin
				if (!cmd_ok_q) begin
					cmd_ok_q <= 1'b1;
					rd_q <= byte_d[CMD_READ_BIT];
					fix_q <= byte_d[CMD_FIXED_BIT];
					page_q <= lsks_page_e'(byte_d[CMD_PAGE_LSB +: 2]);
					ptr_q <= byte_d[CMD_ADDR_LSB +: 3];
				end else if (!fix_q) begin
					ptr_q <= next_ptr(ptr_q, rd_q);
				end
			end
		end
	end

	// Completed data bytes are held here and announced by a toggle
	always_ff @(posedge link.sclk or negedge rstn) begin
		if (!rstn) begin
			wr_tgl_q <= 1'b0;
			rd_tgl_q <= 1'b0;
			ev_page_q <= PG_SEG;
			ev_ptr_q <= '0;
			ev_data_q <= MEM_RESET;
		end else if (link_rst_n && bit_q == BIT_LAST && cmd_ok_q) begin
			ev_page_q <= page_q;
			ev_ptr_q <= ptr_q;
			ev_data_q <= byte_d;
			if (rd_q) begin
				rd_tgl_q <= ~rd_tgl_q;
			end else begin
				wr_tgl_q <= ~wr_tgl_q;
			end
		end
	end

	// Read data leaves on falling edges, starting right after the command byte
	always_ff @(negedge link.sclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			sdo_q <= 1'b1;
			oe_q <= 1'b0;
		end else begin
			oe_q <= cmd_ok_q & rd_q;
			sdo_q <= rd_sel[bit_q];
		end
	end

	assign link.dev_sdo = sdo_q;
	assign link.dev_oe = oe_q;

	// Crossing into the device clock
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sy1_q <= {1'b1, {(SY_W-1){1'b0}}};
			sy2_q <= {1'b1, {(SY_W-1){1'b0}}};
			sy3_q <= {1'b1, {(SY_W-1){1'b0}}};
			sv_q <= {1'b1, {(SY_W-1){1'b0}}};
			svp_q <= {1'b1, {(SY_W-1){1'b0}}};
		end else begin
			sy1_q <= {link.strobe_select, key_in, wr_tgl_q, rd_tgl_q};
			sy2_q <= sy1_q;
			sy3_q <= sy2_q;
			sv_q <= lsks_filt(sy2_q, sy3_q, sv_q);
			svp_q <= sv_q;
		end
	end

	assign wr_ev = sv_q[SY_WR] ^ svp_q[SY_WR];
	assign rd_ev = sv_q[SY_RD] ^ svp_q[SY_RD];

	// Display and configuration memory
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < 6; i++) begin
				seg_mem_q[i] <= MEM_RESET;
			end
			led_mem_q <= MEM_RESET;
			led_seen_q <= 1'b0;
			cfg_q <= CFG_RESET;
		end else if (wr_ev) begin
			unique case (ev_page_q)
				PG_SEG: begin
					if (ev_ptr_q <= SEG_ADDR_MAX) begin
						seg_mem_q[ev_ptr_q] <= ev_data_q;
					end
				end
				PG_LED: begin
					if (ev_ptr_q == ADDR_LED) begin
						led_mem_q <= ev_data_q;
						led_seen_q <= 1'b1;
					end
				end
				PG_SEGCFG: begin
					if (ev_ptr_q == ADDR_CFG) begin
						cfg_q <= ev_data_q;
					end
				end
				PG_LEDCFG: begin
				end
			endcase
		end
	end

	always_comb begin
		unique case (slot_q)
			SL_KEY: slot_len = CNT_W'(KEY_SLOT_CYC);
			SL_LED: slot_len = CNT_W'(LED_SLOT_CYC_P);
			default: slot_len = CNT_W'(DIG_SLOT_CYC_P);
		endcase
	end

	assign slot_last = tick_q == slot_len - CNT_W'(1);
	assign frame_end = slot_last && slot_q == SL_DIG && didx_q >= digit_count(cfg_q) - 3'h1;

	// Free-running slot sequencer with no stop input
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			slot_q <= SL_KEY;
			tick_q <= '0;
			didx_q <= '0;
		end else begin
			tick_q <= slot_last ? '0 : tick_q + CNT_W'(1);
			if (slot_last) begin
				unique case (slot_q)
					SL_KEY: begin
						slot_q <= led_seen_q ? SL_LED : SL_DIG;
						didx_q <= '0;
					end
					SL_LED: begin
						slot_q <= SL_DIG;
						didx_q <= '0;
					end
					SL_DIG: begin
						if (frame_end) begin
							slot_q <= SL_KEY;
						end else begin
							didx_q <= didx_q + 3'h1;
						end
					end
					default: begin
						slot_q <= SL_KEY;
					end
				endcase
			end
		end
	end

	// Key matrix scan, two rows per column
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			step_q <= '0;
			col_q <= '0;
			acc_q <= '0;
			key_q <= '0;
		end else begin
			if (slot_q == SL_KEY && step_q == CNT_W'(KEY_STEP_CYC - 1)) begin
				step_q <= '0;
				col_q <= col_q + 3'h1;
				acc_q[{col_q, 1'b0} +: 2] <= sv_q[SY_KEY +: 2];
			end else if (slot_q != SL_KEY || slot_last) begin
				step_q <= '0;
				col_q <= '0;
			end else begin
				step_q <= step_q + CNT_W'(1);
			end
			if (frame_end) begin
				key_q <= acc_q;
			end
		end
	end

	// Key interrupt: a new key wins over a read in the same cycle
	always_comb begin
		pend_d = pend_q;
		if (rd_ev && ev_page_q == PG_LED && ev_ptr_q == ADDR_KEY_LO) begin
			pend_d[0] = 1'b0;
		end
		if (rd_ev && ev_page_q == PG_LED && ev_ptr_q == ADDR_KEY_HI) begin
			pend_d[1] = 1'b0;
		end
		if (frame_end) begin
			pend_d = pend_d | {|acc_q[15:8], |acc_q[7:0]};
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pend_q <= '0;
			irq_n_q <= 1'b1;
			snap_key_q <= '0;
			snap_led_q <= MEM_RESET;
		end else begin
			pend_q <= pend_d;
			irq_n_q <= ~|pend_d;
			if (sv_q[SY_STB]) begin
				snap_key_q <= key_q;
				snap_led_q <= led_mem_q;
			end
		end
	end

	// Output drive per slot
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			seg_q <= MEM_RESET;
			dig_q <= '0;
		end else begin
			unique case (slot_q)
				SL_KEY: begin
					seg_q <= SEG_ONE << col_q;
					dig_q <= '0;
				end
				SL_LED: begin
					seg_q <= led_mem_q;
					dig_q <= DIG_ONE;
				end
				default: begin
					seg_q <= seg_mem_q[didx_q];
					dig_q <= DIG_ONE << (didx_q + 3'h1);
				end
			endcase
		end
	end

	assign seg_out = seg_q;
	assign dig_out = dig_q;
	assign key_event_irq_n = irq_n_q;
endmodule : lsks_dev

//--- rtl/lsks_pkg.sv
// Shared constants, types and helpers for the LED key-scan frame sequencer link
package lsks_pkg;
	localparam int unsigned CLK_MHZ = 40;
	localparam int unsigned NS_PER_US = 1000;
	localparam int unsigned CNT_W = 16;
	// Frame slot timing
	localparam int unsigned KEY_SLOT_NS = 64000;
	localparam int unsigned KEY_SLOT_CYC = KEY_SLOT_NS * CLK_MHZ / NS_PER_US;
	localparam int unsigned KEY_COLS = 8;
	localparam int unsigned KEY_STEP_CYC = KEY_SLOT_CYC / KEY_COLS;
	localparam int unsigned LED_SLOT_US = 512;
	localparam int unsigned LED_SLOT_CYC = LED_SLOT_US * CLK_MHZ;
	// Serial link timing for the host end
	localparam int unsigned SCLK_MAX_KHZ = 1000;
	localparam int unsigned SCLK_HALF_CYC =
		(CLK_MHZ * 1000 + 2 * SCLK_MAX_KHZ - 1) / (2 * SCLK_MAX_KHZ);
	localparam int unsigned LEAD_NS = 1000;
	localparam int unsigned LEAD_CYC = (LEAD_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
	localparam int unsigned MIN_LOW_NS = 9000;
	localparam int unsigned MIN_LOW_CYC = (MIN_LOW_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
	localparam logic [4:0] XFER_BITS = 5'h10;
	localparam logic [4:0] CMD_BITS = 5'h08;
	// Command byte layout
	localparam int unsigned CMD_ADDR_LSB = 0;
	localparam int unsigned CMD_PAGE_LSB = 3;
	localparam int unsigned CMD_FIXED_BIT = 5;
	localparam int unsigned CMD_READ_BIT = 6;
	localparam logic [2:0] BIT_LAST = 3'h7;
	typedef enum logic [1:0] {
		PG_SEG = 2'h0,
		PG_LED = 2'h1,
		PG_SEGCFG = 2'h2,
		PG_LEDCFG = 2'h3
	} lsks_page_e;
	// Addresses inside pages
	localparam logic [2:0] ADDR_LED = 3'h0;
	localparam logic [2:0] ADDR_KEY_LO = 3'h1;
	localparam logic [2:0] ADDR_KEY_HI = 3'h2;
	localparam logic [2:0] ADDR_CFG = 3'h0;
	localparam logic [2:0] SEG_ADDR_MAX = 3'h5;
	localparam logic [2:0] DIG_MAX = 3'h6;
	localparam int unsigned DIG_W = 7;
	localparam logic [7:0] CFG_RESET = 8'hfb;
	localparam logic [7:0] MEM_RESET = 8'h00;
	localparam logic [7:0] SEG_ONE = 8'h01;
	localparam logic [6:0] DIG_ONE = 7'h01;
	// Synchroniser bit positions in the device clock domain
	localparam int unsigned SY_W = 5;
	localparam int unsigned SY_RD = 0;
	localparam int unsigned SY_WR = 1;
	localparam int unsigned SY_KEY = 2;
	localparam int unsigned SY_STB = 4;
	typedef enum logic [1:0] {
		SL_KEY = 2'b00,
		SL_LED = 2'b01,
		SL_DIG = 2'b11
	} lsks_slot_e;

	// Accept a synchronised bit only when stages two and three agree
	function automatic logic [SY_W-1:0] lsks_filt(input logic [SY_W-1:0] s2,
		input logic [SY_W-1:0] s3, input logic [SY_W-1:0] v);
		lsks_filt = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & v);
	endfunction : lsks_filt
endpackage : lsks_pkg

//--- rtl/lsks_link_if.sv
// Three-wire link between host and device: strobe, clock, shared data line
interface lsks_link_if;
	logic strobe_select;
	logic sclk;
	logic host_sdo;
	logic host_oe;
	logic dev_sdo;
	logic dev_oe;
	logic sdio;

	// Resolved line level; an idle line is pulled high
	assign sdio = host_oe ? host_sdo : (dev_oe ? dev_sdo : 1'b1);

	modport host_mp (
		output strobe_select,
		output sclk,
		output host_sdo,
		output host_oe,
		input sdio
	);
	modport dev_mp (
		input strobe_select,
		input sclk,
		input sdio,
		output dev_sdo,
		output dev_oe
	);
endinterface : lsks_link_if

//--- rtl/lsks_host.sv
// Host end: runs the link clock and strobe for one command plus one data byte
module lsks_host
	import lsks_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	lsks_link_if.host_mp link,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [7:0] req_cmd,
	input wire logic [7:0] req_wdata,
	output logic rsp_valid,
	output logic [7:0] rsp_data
);
	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_LEAD = 3'b001,
		H_LOW = 3'b011,
		H_HIGH = 3'b010,
		H_TAIL = 3'b110,
		H_GAP = 3'b100
	} lsks_hst_e;

	lsks_hst_e st_q;
	logic [CNT_W-1:0] tmr_q;
	logic [CNT_W-1:0] low_q;
	logic [4:0] nbit_q;
	logic [15:0] sh_q;
	logic [7:0] rx_q;
	logic rd_q;
	logic stb_q;
	logic sclk_q;
	logic sdo_q;
	logic oe_q;
	logic ready_q;
	logic rv_q;
	logic [SY_W-1:0] sy1_q;
	logic [SY_W-1:0] sy2_q;
	logic [SY_W-1:0] sy3_q;
	logic [SY_W-1:0] sv_q;
	logic half_done;
	logic lead_done;
	logic rx_phase;

	assign half_done = tmr_q == CNT_W'(SCLK_HALF_CYC - 1);
	assign lead_done = tmr_q >= CNT_W'(LEAD_CYC - 1);
	assign rx_phase = rd_q && (nbit_q >= CMD_BITS);

	// Data line input from the link
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sy1_q <= '0;
			sy2_q <= '0;
			sy3_q <= '0;
			sv_q <= '0;
		end else begin
			sy1_q <= {{(SY_W-1){1'b0}}, link.sdio};
			sy2_q <= sy1_q;
			sy3_q <= sy2_q;
			sv_q <= lsks_filt(sy2_q, sy3_q, sv_q);
		end
	end

	// Time spent with the strobe low
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			low_q <= '0;
		end else if (stb_q) begin
			low_q <= '0;
		end else if (low_q != '1) begin
			low_q <= low_q + CNT_W'(1);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= H_IDLE;
			tmr_q <= '0;
			nbit_q <= '0;
			sh_q <= '0;
			rx_q <= '0;
			rd_q <= 1'b0;
			stb_q <= 1'b1;
			sclk_q <= 1'b1;
			sdo_q <= 1'b1;
			oe_q <= 1'b0;
			ready_q <= 1'b0;
			rv_q <= 1'b0;
		end else begin
			tmr_q <= tmr_q + CNT_W'(1);
			rv_q <= 1'b0;
			unique case (st_q)
				H_IDLE: begin
					ready_q <= 1'b1;
					tmr_q <= '0;
					if (req_valid && ready_q) begin
						ready_q <= 1'b0;
						stb_q <= 1'b0;
						sh_q <= {req_wdata, req_cmd};
						rd_q <= req_cmd[CMD_READ_BIT];
						nbit_q <= '0;
						st_q <= H_LEAD;
					end
				end
				H_LEAD: begin
					if (lead_done) begin
						tmr_q <= '0;
						sclk_q <= 1'b0;
						sdo_q <= sh_q[0];
						oe_q <= 1'b1;
						st_q <= H_LOW;
					end
				end
				H_LOW: begin
					if (half_done) begin
						tmr_q <= '0;
						sclk_q <= 1'b1;
						if (rx_phase) begin
							rx_q <= {sv_q[0], rx_q[7:1]};
						end
						if (rd_q && nbit_q == CMD_BITS - 5'h01) begin
							oe_q <= 1'b0;
						end
						sh_q <= {1'b0, sh_q[15:1]};
						nbit_q <= nbit_q + 5'h01;
						st_q <= H_HIGH;
					end
				end
				H_HIGH: begin
					if (half_done) begin
						tmr_q <= '0;
						if (nbit_q == XFER_BITS) begin
							st_q <= H_TAIL;
						end else begin
							sclk_q <= 1'b0;
							sdo_q <= sh_q[0];
							oe_q <= !rx_phase;
							st_q <= H_LOW;
						end
					end
				end
				H_TAIL: begin
					if (lead_done && low_q >= CNT_W'(MIN_LOW_CYC - 1)) begin
						tmr_q <= '0;
						stb_q <= 1'b1;
						oe_q <= 1'b0;
						rv_q <= rd_q;
						st_q <= H_GAP;
					end
				end
				H_GAP: begin
					if (lead_done) begin
						st_q <= H_IDLE;
					end
				end
				default: begin
					st_q <= H_IDLE;
				end
			endcase
		end
	end

	assign link.strobe_select = stb_q;
	assign link.sclk = sclk_q;
	assign link.host_sdo = sdo_q;
	assign link.host_oe = oe_q;
	assign req_ready = ready_q;
	assign rsp_valid = rv_q;
	assign rsp_data = rx_q;
endmodule : lsks_host

//--- bench/lsks_assertions.sv
// Concurrent checks on the three-wire link between host and device ends
module lsks_assertions
	import lsks_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic strobe_select,
	input wire logic sclk,
	input wire logic host_sdo,
	input wire logic host_oe,
	input wire logic dev_sdo,
	input wire logic dev_oe,
	input wire logic sdio
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HALF_M1 = SCLK_HALF_CYC - 1;
	logic sclk_q;
	logic rd_q;
	logic [4:0] rise_q;
	logic [15:0] low_q;
	logic [15:0] hold_q;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	// Link clock history and cycles since its last change
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sclk_q <= 1'b1;
			hold_q <= 16'hffff;
		end else begin
			sclk_q <= sclk;
			hold_q <= (sclk != sclk_q) ? 16'h0000 : hold_q + {15'h0000, hold_q != 16'hffff};
		end
	end
	// Rising edges and read flag within one transfer
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rise_q <= 5'h00;
			rd_q <= 1'b0;
		end else if (strobe_select) begin
			rise_q <= 5'h00;
			rd_q <= 1'b0;
		end else if (sclk && !sclk_q) begin
			rise_q <= rise_q + 5'h01;
			rd_q <= (rise_q == 5'h06) ? sdio : rd_q;
		end
	end
	// Cycles with strobe held low
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			low_q <= 16'h0000;
		end else begin
			low_q <= strobe_select ? 16'h0000 : low_q + {15'h0000, low_q != 16'hffff};
		end
	end

	a_lead_time: assert property ($rose(sclk) && rise_q == 5'h00 |-> low_q >= LEAD_CYC)
		else $error("link clock rose too soon after strobe fell");
	a_min_low: assert property ($rose(strobe_select) |-> low_q >= MIN_LOW_CYC)
		else $error("strobe low time too short");
	a_half_period: assert property ($changed(sclk) |-> hold_q >= HALF_M1)
		else $error("link clock half period too short");
	a_host_release: assert property ($rose(sclk) && rise_q == 5'h07 && rd_q |-> !host_oe)
		else $error("host still drives data after read command");
	a_read_turn: assert property ($fell(sclk) && rise_q == 5'h08 && rd_q |-> ##[0:HALF_M1] dev_oe)
		else $error("device did not start read data");
	a_cmd_quiet: assert property (rise_q < 5'h08 |-> !dev_oe)
		else $error("device drives during command byte");
	a_write_quiet: assert property (!strobe_select && rise_q >= 5'h07 && !rd_q |-> !dev_oe)
		else $error("device drives during a write");
	a_no_clash: assert property (!(host_oe && dev_oe))
		else $error("both ends drive the data line");
	a_oe_hold: assert property (dev_oe && !strobe_select |=> dev_oe || strobe_select)
		else $error("device dropped read data mid transfer");
	a_bit_change: assert property (dev_oe && $changed(dev_sdo) |-> !sclk)
		else $error("device data changed while link clock high");
	a_idle_link: assert property (strobe_select |-> sclk && !dev_oe)
		else $error("link not idle with strobe high");
	a_full_frame: assert property ($rose(strobe_select) |-> rise_q == 5'h10)
		else $error("transfer ended with wrong bit count");

	c_read: cover property ($rose(dev_oe));
	c_write: cover property ($rose(strobe_select) && !rd_q);
	c_bits: cover property (rise_q == 5'h10);
endmodule : lsks_assertions

//--- bench/lsks_tb_top.sv
// Self-checking bench: host and device ends joined over the link
module lsks_tb_top
	import lsks_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SLOT = 64;
	logic clk, rstn, req_valid, req_ready, rsp_valid, key_event_irq_n;
	logic [7:0] req_cmd, req_wdata, rsp_data, seg_out, rd;
	logic [1:0] key_in;
	logic [6:0] dig_out;
	int fail_count, cmp_count;

	lsks_link_if link_if();
	lsks_host lsks_host_inst (.clk(clk), .rstn(rstn), .link(link_if), .req_valid(req_valid),
		.req_ready(req_ready), .req_cmd(req_cmd), .req_wdata(req_wdata),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data));
	lsks_dev #(.LED_SLOT_CYC_P(SLOT), .DIG_SLOT_CYC_P(SLOT)) lsks_dev_inst (.clk(clk),
		.rstn(rstn), .link(link_if), .key_in(key_in), .seg_out(seg_out),
		.dig_out(dig_out), .key_event_irq_n(key_event_irq_n));
	lsks_assertions lsks_assertions_inst (.clk(clk), .rstn(rstn),
		.strobe_select(link_if.strobe_select), .sclk(link_if.sclk),
		.host_sdo(link_if.host_sdo), .host_oe(link_if.host_oe), .dev_sdo(link_if.dev_sdo),
		.dev_oe(link_if.dev_oe), .sdio(link_if.sdio));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic chk_cnt(input string what, input int exp, input int got);
		cmp_count++;
		if (got != exp) begin
			fail_count++;
			$display("unexpected %s: expected %0d seen %0d", what, exp, got);
		end
	endtask : chk_cnt

	task automatic hang(input string what);
		fail_count++;
		$display("unexpected %s: wait ran out", what);
		complete_run();
	endtask : hang

	// One command byte plus one data byte; read data returned in r
	task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] r);
		int n;
		r = 8'hxx;
		for (n = 0; req_ready !== 1'b1; n++) begin
			if (n > 2000) hang("request ready");
			@(negedge clk);
		end
		req_cmd = cmd;
		req_wdata = wd;
		req_valid = 1'b1;
		@(negedge clk);
		req_valid = 1'b0;
		for (n = 0; req_ready !== 1'b1; n++) begin
			if (n > 2000) hang("transfer done");
			if (rsp_valid === 1'b1) r = rsp_data;
			@(negedge clk);
		end
	endtask : xfer

	task automatic wait_dig(input logic zero);
		int n;
		for (n = 0; (dig_out === 7'h00) != zero; n++) begin
			if (n > 8000) hang("digit drive");
			@(negedge clk);
		end
	endtask : wait_dig

	// Follows one whole frame and compares its slot order and lengths
	task automatic frame_seq(input logic [47:0] el, input int n, input logic [7:0] led);
		int i;
		int len;
		int g;
		logic [6:0] prev;
		i = 0;
		len = 0;
		prev = 7'h00;
		wait_dig(1'b0);
		wait_dig(1'b1);
		for (g = 0; g < 8000; g++) begin
			@(negedge clk);
			len++;
			if (dig_out !== prev) begin
				if (prev === 7'h00) chk_cnt("key slot cycles", KEY_SLOT_CYC, len);
				else chk_cnt("slot cycles", SLOT, len);
				if (dig_out === 7'h00) break;
				chk("slot digit", {1'b0, el[i*8 +: 7]}, {1'b0, dig_out});
				if (dig_out === 7'h01) chk("led segments", led, seg_out);
				i++;
				len = 0;
				prev = dig_out;
			end
		end
		if (g >= 8000) hang("frame end");
		chk_cnt("slot count", n, i);
	endtask : frame_seq

	task automatic t_reset();
		chk("reset link", 8'h32, {2'b00, link_if.strobe_select, link_if.sclk, link_if.dev_oe,
			link_if.host_oe, key_event_irq_n, req_ready});
		chk("reset digits", 8'h00, {1'b0, dig_out});
	endtask : t_reset

	task automatic t_keys();
		int n;
		for (n = 0; key_event_irq_n !== 1'b0; n++) begin
			if (n > 6000) hang("key event");
			@(negedge clk);
		end
		key_in = 2'b00;
		xfer(8'h49, 8'h00, rd);
		chk("key byte one", 8'hff, rd);
		chk("irq after one", 8'h00, {7'h00, key_event_irq_n});
		xfer(8'h4a, 8'h00, rd);
		chk("key byte two", 8'hff, rd);
		chk("irq after two", 8'h01, {7'h00, key_event_irq_n});
	endtask : t_keys

	task automatic t_bad_read();
		xfer(8'h40, 8'h00, rd);
		chk("segment page read", 8'h00, rd);
		xfer(8'h4b, 8'h00, rd);
		chk("unmapped read", 8'h00, rd);
	endtask : t_bad_read

	task automatic t_led();
		frame_seq(48'h0000_0008_0402, 3, 8'h00);
		xfer(8'h08, 8'ha5, rd);
		frame_seq(48'h0000_0804_0201, 4, 8'ha5);
		frame_seq(48'h0000_0804_0201, 4, 8'ha5);
		xfer(8'h48, 8'h00, rd);
		chk("led read back", 8'ha5, rd);
	endtask : t_led

	task automatic t_digits();
		xfer(8'h10, 8'h05, rd);
		frame_seq(48'h2010_0804_0201, 6, 8'ha5);
		xfer(8'h30, 8'h00, rd);
		frame_seq(48'h0000_0000_0201, 2, 8'ha5);
	endtask : t_digits

	task automatic t_seg();
		int n;
		xfer(8'h00, 8'h3c, rd);
		for (n = 0; dig_out !== 7'h02; n++) begin
			if (n > 8000) hang("digit one");
			@(negedge clk);
		end
		chk("digit one segments", 8'h3c, seg_out);
	endtask : t_seg

	initial begin
		rstn = 1'b1;
		req_valid = 1'b0;
		req_cmd = 8'h00;
		req_wdata = 8'h00;
		key_in = 2'b11;
		fail_count = 0;
		cmp_count = 0;
		// Reset falls after time zero so every reset process sees the edge
		#1;
		rstn = 1'b0;
		repeat (5) @(negedge clk);
		t_reset();
		repeat (5) @(negedge clk);
		rstn = 1'b1;
		t_keys();
		t_bad_read();
		t_led();
		t_digits();
		t_seg();
		complete_run();
	end
endmodule : lsks_tb_top
